// ---- core/lcd_i2c_pkg.sv ----
// Constants and types shared by the LCD driver write port and its buffer
package lcd_i2c_pkg;

	// Slave address: upper six bits fixed, lowest address bit from strap
	localparam logic [5:0] SLAVE_ADDR_UPPER = 6'h1c;
	localparam int ADDR_UPPER_MSB = 7;
	localparam int ADDR_UPPER_LSB = 2;
	localparam int ADDR_SELECT_BIT = 1;
	localparam int DIRECTION_BIT = 0;

	// Control byte fields
	localparam int CONTINUE_BIT = 7;
	localparam int DESTINATION_BIT = 6;

	// Command byte fields
	localparam logic [4:0] DEVICE_SELECT_PATTERN = 5'h1c;
	localparam int DEVICE_SELECT_MSB = 7;
	localparam int DEVICE_SELECT_LSB = 3;
	localparam int LOAD_POINTER_FLAG_BIT = 7;
	localparam logic [6:0] POINTER_MAX = 7'h3b;

	// Reset values
	localparam logic [5:0] POINTER_RESET = 6'h00;
	localparam logic [2:0] SUBADDR_RESET = 3'h0;

	// Bits in a byte
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// One decoded byte handed to the display controller
	typedef struct packed {
		logic is_display;
		logic [5:0] ram_addr;
		logic [2:0] subaddr;
		logic [7:0] data;
	} item_type;

	// Link engine states
	typedef enum logic [3:0] {
		LS_IDLE = 4'b0001,
		LS_RECV = 4'b0010,
		LS_ACK = 4'b0100,
		LS_IGNORE = 4'b1000
	} link_state_type;

	// All state of the link clock domain
	typedef struct packed {
		link_state_type state;
		logic rst_meta;
		logic rst_sync;
		logic scl_meta;
		logic scl_sync;
		logic scl_prev;
		logic sda_meta;
		logic sda_sync;
		logic sda_prev;
		logic strap_meta;
		logic strap_sync;
		logic [2:0] pins_meta;
		logic [2:0] pins_sync;
		logic ack_meta;
		logic ack_sync;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic addr_phase;
		logic expect_control;
		logic continue_flag;
		logic destination_select;
		logic [5:0] pointer;
		logic [2:0] subaddr;
		logic sda_oe;
		logic sda_out;
		logic req;
		item_type item;
	} link_type;

	// All state of the core clock domain except the item buffer
	typedef struct packed {
		logic req_meta;
		logic req_sync;
		logic req_seen;
		logic out_valid;
		item_type out_item;
	} core_type;

	// Two-entry buffer state
	typedef struct packed {
		item_type [1:0] entry;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} buffer_type;

endpackage : lcd_i2c_pkg

// ---- core/item_buffer.sv ----
// Two-entry buffer between the bus crossing and the display controller port
`timescale 1ns/1ns
module item_buffer (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire lcd_i2c_pkg::item_type in_item,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output lcd_i2c_pkg::item_type out_item
);

	lcd_i2c_pkg::buffer_type b;
	lcd_i2c_pkg::buffer_type next_b;
	logic push;
	logic pop;

	// Honest flags straight from the count
	assign in_ready = (b.count != 2'h2);
	assign out_valid = (b.count != 2'h0);
	assign out_item = b.entry[b.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state: write, read and count
	always_comb begin
		next_b = b;
		for (int i = 0; i < 2; i++) begin
			if (push && (b.wr_ptr == i[0])) begin
				next_b.entry[i] = in_item;
			end
		end
		if (push) begin
			next_b.wr_ptr = ~b.wr_ptr;
		end
		if (pop) begin
			next_b.rd_ptr = ~b.rd_ptr;
		end
		case ({push, pop})
			2'b10: next_b.count = b.count + 2'h1;
			2'b01: next_b.count = b.count - 2'h1;
			default: next_b.count = b.count;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			b <= '0;
		end else begin
			b <= next_b;
		end
	end

endmodule : item_buffer

// ---- core/lcd_i2c_write_port.sv ----
// Write-only I2C slave front end of a multiplexed LCD segment driver
`timescale 1ns/1ns
module lcd_i2c_write_port (
	// Core clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Link oversampling clock
	input wire logic LINK_CLK,
	// Bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Straps
	input wire logic ADDRESS_SELECT_STRAP,
	input wire logic SUBADDR_PIN_BIT0,
	input wire logic SUBADDR_PIN_BIT1,
	input wire logic SUBADDR_PIN_BIT2,
	// Display controller side
	output logic ITEM_VALID,
	input wire logic ITEM_READY,
	output lcd_i2c_pkg::item_type ITEM,
	// Status
	output logic [5:0] DATA_POINTER,
	output logic [2:0] SUBADDR_COUNTER
);

	lcd_i2c_pkg::link_type l;
	lcd_i2c_pkg::link_type next_l;
	lcd_i2c_pkg::core_type c;
	lcd_i2c_pkg::core_type next_c;

	logic buf_in_ready;
	logic buf_in_valid;
	logic buf_out_valid;
	logic buf_out_ready;
	lcd_i2c_pkg::item_type buf_out_item;

	// Link side: pin sampling, byte engine and decoding
	always_comb begin
		logic start_cond;
		logic stop_cond;
		logic scl_rise;
		logic scl_fall;
		logic busy;
		logic give_ack;
		logic own_slot;
		logic [7:0] byte_in;
		start_cond = 1'b0;
		stop_cond = 1'b0;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		busy = 1'b0;
		give_ack = 1'b0;
		own_slot = 1'b0;
		byte_in = l.shift;
		next_l = l;

		// Two-flop synchronisers
		next_l.rst_meta = RST;
		next_l.rst_sync = l.rst_meta;
		next_l.scl_meta = SCL_IN;
		next_l.scl_sync = l.scl_meta;
		next_l.scl_prev = l.scl_sync;
		next_l.sda_meta = SDA_IN;
		next_l.sda_sync = l.sda_meta;
		next_l.sda_prev = l.sda_sync;
		next_l.strap_meta = ADDRESS_SELECT_STRAP;
		next_l.strap_sync = l.strap_meta;
		next_l.pins_meta = {SUBADDR_PIN_BIT2, SUBADDR_PIN_BIT1, SUBADDR_PIN_BIT0};
		next_l.pins_sync = l.pins_meta;
		next_l.ack_meta = c.req_seen;
		next_l.ack_sync = l.ack_meta;

		// Bus events on synchronised levels
		start_cond = l.scl_sync && l.scl_prev && l.sda_prev && !l.sda_sync;
		stop_cond = l.scl_sync && l.scl_prev && !l.sda_prev && l.sda_sync;
		scl_rise = l.scl_sync && !l.scl_prev;
		scl_fall = !l.scl_sync && l.scl_prev;
		busy = (l.req != l.ack_sync);
		own_slot = (l.subaddr == l.pins_sync);

		// SDA is never driven high; only the pull-down for acknowledge
		next_l.sda_out = 1'b0;

		if (start_cond) begin
			// Repeated START restarts address reception
			next_l.state = lcd_i2c_pkg::LS_RECV;
			next_l.bit_cnt = 4'h0;
			next_l.addr_phase = 1'b1;
			next_l.sda_oe = 1'b0;
		end else if (stop_cond) begin
			// STOP ends any transfer, ignored or not
			next_l.state = lcd_i2c_pkg::LS_IDLE;
			next_l.sda_oe = 1'b0;
		end else begin
			unique case (l.state)
				lcd_i2c_pkg::LS_IDLE: begin
					next_l.sda_oe = 1'b0;
				end
				lcd_i2c_pkg::LS_IGNORE: begin
					next_l.sda_oe = 1'b0;
				end
				lcd_i2c_pkg::LS_RECV: begin
					if (scl_rise && (l.bit_cnt != lcd_i2c_pkg::BITS_PER_BYTE)) begin
						next_l.shift = {l.shift[6:0], l.sda_sync};
						next_l.bit_cnt = l.bit_cnt + 4'h1;
					end
					if (scl_fall && (l.bit_cnt == lcd_i2c_pkg::BITS_PER_BYTE)) begin
						next_l.state = lcd_i2c_pkg::LS_ACK;
						if (l.addr_phase) begin
							// Address byte: two addresses, strap picks one, write only
							if ((byte_in[lcd_i2c_pkg::ADDR_UPPER_MSB:lcd_i2c_pkg::ADDR_UPPER_LSB]
								== lcd_i2c_pkg::SLAVE_ADDR_UPPER)
								&& (byte_in[lcd_i2c_pkg::ADDR_SELECT_BIT] == l.strap_sync)
								&& !byte_in[lcd_i2c_pkg::DIRECTION_BIT]) begin
								give_ack = 1'b1;
								next_l.addr_phase = 1'b0;
								next_l.expect_control = 1'b1;
							end else begin
								next_l.state = lcd_i2c_pkg::LS_IGNORE;
							end
						end else if (l.expect_control) begin
							// Control byte: always acknowledged
							give_ack = 1'b1;
							next_l.continue_flag = byte_in[lcd_i2c_pkg::CONTINUE_BIT];
							next_l.destination_select = byte_in[lcd_i2c_pkg::DESTINATION_BIT];
							next_l.expect_control = 1'b0;
						end else begin
							// After a data byte, a control byte follows only if continuing
							next_l.expect_control = l.continue_flag;
							// Handed-over word changes only with its toggle, so it stands while the core reads it
							if (!l.destination_select) begin
								// Command byte for the decoder
								give_ack = !busy;
								if (!busy) begin
									next_l.req = ~l.req;
									next_l.item.is_display = 1'b0;
									next_l.item.ram_addr = l.pointer;
									next_l.item.subaddr = l.subaddr;
									next_l.item.data = byte_in;
									if (byte_in[lcd_i2c_pkg::DEVICE_SELECT_MSB:lcd_i2c_pkg::DEVICE_SELECT_LSB]
										== lcd_i2c_pkg::DEVICE_SELECT_PATTERN) begin
										next_l.subaddr = byte_in[2:0];
									end
									if (!byte_in[lcd_i2c_pkg::LOAD_POINTER_FLAG_BIT]) begin
										if (byte_in[6:0] > lcd_i2c_pkg::POINTER_MAX) begin
											next_l.pointer = lcd_i2c_pkg::POINTER_MAX[5:0];
										end else begin
											next_l.pointer = byte_in[5:0];
										end
									end
								end
							end else begin
								// Display byte: only the matching subaddress answers and stores
								give_ack = own_slot && !busy;
								if (own_slot && !busy) begin
									next_l.req = ~l.req;
									next_l.item.is_display = 1'b1;
									next_l.item.ram_addr = l.pointer;
									next_l.item.subaddr = l.subaddr;
									next_l.item.data = byte_in;
								end
								// Every addressed device advances, matching or not
								if (l.pointer == lcd_i2c_pkg::POINTER_MAX[5:0]) begin
									next_l.pointer = lcd_i2c_pkg::POINTER_RESET;
									next_l.subaddr = l.subaddr + 3'h1;
								end else begin
									next_l.pointer = l.pointer + 6'h01;
								end
							end
						end
						next_l.sda_oe = give_ack;
					end
				end
				lcd_i2c_pkg::LS_ACK: begin
					// Release after the acknowledge clock
					if (scl_fall) begin
						next_l.sda_oe = 1'b0;
						next_l.bit_cnt = 4'h0;
						next_l.state = lcd_i2c_pkg::LS_RECV;
					end
				end
			endcase
		end
	end

	// Link state register; reset arrives through its own synchroniser
	always_ff @(posedge LINK_CLK) begin
		if (l.rst_sync) begin
			l <= '0;
			l.state <= lcd_i2c_pkg::LS_IDLE;
			l.pointer <= lcd_i2c_pkg::POINTER_RESET;
			l.subaddr <= lcd_i2c_pkg::SUBADDR_RESET;
			l.scl_meta <= next_l.scl_meta; // Bus and reset samplers run on, no false edge after reset
			l.scl_sync <= next_l.scl_sync;
			l.scl_prev <= next_l.scl_prev;
			l.sda_meta <= next_l.sda_meta;
			l.sda_sync <= next_l.sda_sync;
			l.sda_prev <= next_l.sda_prev;
			l.rst_meta <= next_l.rst_meta;
			l.rst_sync <= next_l.rst_sync;
		end else begin
			l <= next_l;
		end
	end

	// Core side: take handed-over items into the buffer, then to the port
	always_comb begin
		next_c = c;
		next_c.req_meta = l.req;
		next_c.req_sync = c.req_meta;
		if (buf_in_valid && buf_in_ready) begin
			next_c.req_seen = c.req_sync;
		end
		if (buf_out_ready) begin
			next_c.out_valid = buf_out_valid;
			next_c.out_item = buf_out_item;
		end
	end

	// Offer a word only while the handshake shows a new one
	assign buf_in_valid = (c.req_sync != c.req_seen);
	assign buf_out_ready = !c.out_valid || ITEM_READY;

	// Core state register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	// Stall by the display controller holds words here
	item_buffer u_buffer (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_item(l.item),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_item(buf_out_item)
	);

	// Outputs straight from flops
	assign SDA_OUT = l.sda_out;
	assign SDA_OE = l.sda_oe;
	assign ITEM_VALID = c.out_valid;
	assign ITEM = c.out_item;
	assign DATA_POINTER = l.pointer;
	assign SUBADDR_COUNTER = l.subaddr;

endmodule : lcd_i2c_write_port

// ---- verification/i2c_master_model.sv ----
// Bus master model driving SCL and SDA
`timescale 1ns/1ns
module i2c_master_model (
	// Bus lines
	output logic scl,
	output logic sda,
	input wire logic sda_line
);
	localparam int HALF = 320;
	// Idle bus, both lines high
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// START or repeated START, ends with SCL low
	task automatic start;
		#(HALF / 4) sda = 1'b1;
		#HALF scl = 1'b1;
		#HALF sda = 1'b0;
		#HALF scl = 1'b0;
	endtask : start
	// STOP from SCL low
	task automatic stop;
		#(HALF / 4) sda = 1'b0;
		#HALF scl = 1'b1;
		#HALF sda = 1'b1;
		#HALF;
	endtask : stop
	// Byte MSB first, SDA released on the ninth clock
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#(HALF / 4) sda = b[i];
			#HALF scl = 1'b1;
			#HALF scl = 1'b0;
		end
		#(HALF / 4) sda = 1'b1;
		#HALF scl = 1'b1;
		#(HALF / 2) ack = ~sda_line;
		#(HALF / 2) scl = 1'b0;
	endtask : wbyte
endmodule : i2c_master_model

// ---- verification/lcd_i2c_write_port_properties.sv ----
// Concurrent checks on the write port pins
`timescale 1ns/1ns
module lcd_i2c_write_port_properties (
	// Clocks and reset
	input wire logic CORE_CLK,
	input wire logic LINK_CLK,
	input wire logic RST,
	// Bus side
	input wire logic SCL_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	// Display side
	input wire logic ITEM_VALID,
	input wire logic ITEM_READY,
	input wire lcd_i2c_pkg::item_type ITEM,
	input wire logic [5:0] DATA_POINTER,
	input wire logic [2:0] SUBADDR_COUNTER
);
	AST_SDA_ZERO: assert property (@(posedge LINK_CLK) disable iff (RST) SDA_OUT == 1'b0)
		else $error("SDA data driven high");
	AST_OE_RISE: assert property (@(posedge LINK_CLK) disable iff (RST) $rose(SDA_OE) |-> !SCL_IN)
		else $error("Acknowledge began with SCL high");
	AST_OE_FALL: assert property (@(posedge LINK_CLK) disable iff (RST) $fell(SDA_OE) |-> !SCL_IN)
		else $error("Acknowledge ended with SCL high");
	AST_OE_HOLD: assert property (@(posedge LINK_CLK) disable iff (RST) $rose(SDA_OE) |=> SDA_OE [*8])
		else $error("Acknowledge too short");
	AST_PTR_RANGE: assert property (@(posedge LINK_CLK) disable iff (RST) DATA_POINTER <= 6'h3b)
		else $error("Pointer out of range");
	AST_SUB_STEADY: assert property (@(posedge LINK_CLK) disable iff (RST)
		(DATA_POINTER - $past(DATA_POINTER)) == 6'h01 |-> $stable(SUBADDR_COUNTER))
		else $error("Subaddress moved on plain step");
	AST_VALID_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
		ITEM_VALID && !ITEM_READY |=> ITEM_VALID)
		else $error("Item dropped while stalled");
	AST_ITEM_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
		ITEM_VALID && !ITEM_READY |=> $stable(ITEM))
		else $error("Item changed while stalled");
	AST_RAM_ADDR: assert property (@(posedge CORE_CLK) disable iff (RST)
		ITEM_VALID && ITEM.is_display |-> ITEM.ram_addr <= 6'h3b)
		else $error("RAM address out of range");
	// Main scenarios
	cover property (@(posedge CORE_CLK) ITEM_VALID && ITEM.is_display);
	cover property (@(posedge CORE_CLK) ITEM_VALID && !ITEM_READY);
	cover property (@(posedge LINK_CLK) $rose(SDA_OE));
endmodule : lcd_i2c_write_port_properties
bind lcd_i2c_write_port lcd_i2c_write_port_properties props (.CORE_CLK(CORE_CLK), .LINK_CLK(LINK_CLK),
	.RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ITEM_VALID(ITEM_VALID),
	.ITEM_READY(ITEM_READY), .ITEM(ITEM), .DATA_POINTER(DATA_POINTER), .SUBADDR_COUNTER(SUBADDR_COUNTER));

// ---- verification/tb_lcd_i2c_write_port.sv ----
// Self-checking bench for the write port
`timescale 1ns/1ns
module tb_lcd_i2c_write_port;
	// Clocks, reset and pins
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic sda_m;
	logic sda_line;
	logic sda_out;
	logic sda_oe;
	logic strap = 1'b0;
	logic [2:0] pins = 3'h0;
	logic item_ready = 1'b0;
	logic item_valid;
	lcd_i2c_pkg::item_type item;
	logic [5:0] data_pointer;
	logic [2:0] subaddr_counter;
	logic ack;
	int n_mismatch = 0;
	int tests_run = 0;
	// Clocks of unrelated phase
	always #10 core_clk = ~core_clk;
	always #16 link_clk = ~link_clk;
	// Wired line with pull-up
	assign sda_line = sda_m & ~sda_oe;
	i2c_master_model master (.scl(scl), .sda(sda_m), .sda_line(sda_line));
	lcd_i2c_write_port dut (.CORE_CLK(core_clk), .RST(rst), .LINK_CLK(link_clk), .SCL_IN(scl),
		.SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDRESS_SELECT_STRAP(strap),
		.SUBADDR_PIN_BIT0(pins[0]), .SUBADDR_PIN_BIT1(pins[1]), .SUBADDR_PIN_BIT2(pins[2]),
		.ITEM_VALID(item_valid), .ITEM_READY(item_ready), .ITEM(item), .DATA_POINTER(data_pointer),
		.SUBADDR_COUNTER(subaddr_counter));
	// Compare tasks
	task automatic chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t ack %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_stat(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t status %h expected %h", $time, got, exp);
		end
	endtask : chk_stat
	task automatic chk_item(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t item %h expected %h", $time, got, exp);
		end
	endtask : chk_item
	// One byte and its acknowledge
	task automatic send(input logic [7:0] b, input logic e);
		master.wbyte(b, ack);
		chk_bit(ack, e);
	endtask : send
	// Wait for an item, judge it, take it
	task automatic pop(input logic [17:0] exp);
		int i;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (item_valid !== 1'b1 && i < 400);
		chk_item({item.is_display, item.is_display ? {item.ram_addr, item.subaddr} : 9'h000, item.data}, exp);
		item_ready <= 1'b1;
		@(posedge core_clk);
		item_ready <= 1'b0;
	endtask : pop
	// Foreign address, wrong strap bit, read direction
	task automatic t_addr;
		logic [7:0] bad [3];
		bad = '{8'h72, 8'h71, 8'h40};
		for (int i = 0; i < 3; i++) begin
			master.start();
			send(bad[i], 1'b0);
			send(8'h00, 1'b0);
			master.stop();
		end
		$display("address test done");
	endtask : t_addr
	// Display writes with a stall, then commands after a repeated START
	task automatic t_display;
		master.start();
		send(8'h70, 1'b1);
		send(8'h40, 1'b1);
		send(8'ha5, 1'b1);
		send(8'h3c, 1'b1);
		pop({1'b1, 6'h00, 3'h0, 8'ha5});
		pop({1'b1, 6'h01, 3'h0, 8'h3c});
		master.start();
		send(8'h70, 1'b1);
		send(8'h00, 1'b1);
		send(8'he3, 1'b1);
		pop({1'b0, 6'h00, 3'h0, 8'he3});
		send(8'h7f, 1'b1);
		pop({1'b0, 6'h00, 3'h0, 8'h7f});
		master.stop();
		chk_stat({data_pointer, subaddr_counter}, {6'h3b, 3'h3});
		$display("display test done");
	endtask : t_display
	// Foreign subaddress with continue flag and pointer wrap
	task automatic t_mismatch;
		master.start();
		send(8'h70, 1'b1);
		send(8'hc0, 1'b1);
		send(8'h11, 1'b0);
		send(8'h40, 1'b1);
		send(8'h22, 1'b0);
		master.stop();
		chk_stat({data_pointer, subaddr_counter}, {6'h01, 3'h4});
		$display("subaddress test done");
	endtask : t_mismatch
	// Strap high and non-zero subaddress pins: second address, own slot
	task automatic t_cluster;
		@(posedge core_clk);
		strap <= 1'b1;
		pins <= 3'h4;
		repeat (8) @(posedge core_clk);
		master.start();
		send(8'h70, 1'b0);
		send(8'h40, 1'b0);
		master.start();
		send(8'h72, 1'b1);
		send(8'h40, 1'b1);
		send(8'h5a, 1'b1);
		pop({1'b1, 6'h01, 3'h4, 8'h5a});
		master.stop();
		chk_stat({data_pointer, subaddr_counter}, {6'h02, 3'h4});
		$display("cluster test done");
	endtask : t_cluster
	// Verdict and end of run
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk_stat({data_pointer, subaddr_counter}, 9'h000);
		t_addr();
		t_display();
		t_mismatch();
		t_cluster();
		complete_run();
	end
	// Watchdog
	initial begin
		#1000000;
		n_mismatch++;
		complete_run();
	end
endmodule : tb_lcd_i2c_write_port
